// ==== include/ssc_consts.svh ====
/*
  Offsets, field positions, reset values and fixed widths of the
  supervisor status and counter-delegation CSR block.
  Assumes a 12-bit CSR address space and a 64-bit supervisor word.
*/
`ifndef SSC_CONSTS_SVH
`define SSC_CONSTS_SVH

`define SSC_XLEN 64
`define SSC_NCNT 32
`define SSC_NIRQ 16

// CSR addresses
`define SSC_A_SSTATUS 12'h100
`define SSC_A_SIE 12'h104
`define SSC_A_SCNTINH 12'h120
`define SSC_A_VSIE 12'h204
`define SSC_A_VSIP 12'h244
`define SSC_A_MSTATUS 12'h300
`define SSC_A_MIDELEG 12'h303
`define SSC_A_MCNTEN 12'h306
`define SSC_A_MVIEN 12'h308
`define SSC_A_MVIP 12'h309
`define SSC_A_MENVCFG 12'h30A
`define SSC_A_MCNTINH 12'h320
`define SSC_A_HIDELEG 12'h603
`define SSC_A_HVIEN 12'h618
`define SSC_A_HVIP 12'h645
`define SSC_A_SCNTOVF 12'hDA0

// Status, menvcfg and overflow-interrupt field positions
`define SSC_B_SIE 1
`define SSC_B_SUP_PRIOR_IRQ_ENABLE 5
`define SSC_B_SPP 8
`define SSC_B_SD 63
`define SSC_B_CDE 60
`define SSC_B_LCOF 13

// Reset values
`define SSC_R_SIE 1'h0
`define SSC_R_SUP_PRIOR_IRQ_ENABLE 1'h0
`define SSC_R_SPP 1'h0
`define SSC_R_CDE 1'h0
`define SSC_R_CNT 32'h0
`define SSC_R_IEN 16'h0

// Index of each local-overflow bit cell
`define SSC_L_MVIP 0
`define SSC_L_MVIEN 1
`define SSC_L_HVIP 2
`define SSC_L_HVIEN 3
`define SSC_L_VSIE 4
`define SSC_L_MIDELEG 5
`define SSC_L_HIDELEG 6
`define SSC_NLCOF 7

// Delegation cells are optional; 1 makes them writable
`define SSC_DELEG_LCOF_IMPL 1'h1

`endif

// ==== include/ssc_pkg.sv ====
/*
  Types shared by the supervisor CSR block.
  Assumes ssc_consts.svh sits beside it on the include path.
*/
package ssc_pkg;
  typedef enum logic [1:0] {
    SSC_PRIV_U = 2'h0,
    SSC_PRIV_S = 2'h1,
    SSC_PRIV_M = 2'h3
  } ssc_priv_t;
endpackage

// ==== rtl/ssc_bit_cell.sv ====
/*
  One writable CSR bit with a constant reset value.
  Assumes the write strobe is already qualified by the access check.
*/
module ssc_bit_cell
  import ssc_pkg::*;
#(
  parameter logic RST_VAL = 1'h0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic wd,
  output logic q
);
  logic q_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_ff <= RST_VAL;
    end else if (we) begin
      q_ff <= wd;
    end
  end
  assign q = q_ff;
endmodule

// ==== rtl/ssc_access_check.sv ====
/*
  Combinational privilege check for one CSR access.
  Assumes the address is stable for the request cycle and that the
  caller states whether the address is implemented.
*/
`include "ssc_consts.svh"
module ssc_access_check
  import ssc_pkg::*;
(
  // Access
  input wire logic [11:0] addr,
  input wire logic we,
  input wire logic known,
  // Hart state
  input wire logic [1:0] priv,
  input wire logic virt,
  input wire logic cde,
  // Verdict
  output logic illegal,
  output logic virtual_exc
);
  wire [1:0] need = addr[9:8];
  wire ro = (addr[11:10] == 2'h3);
  wire is_inh = (addr == `SSC_A_SCNTINH);
  wire is_ovf = (addr == `SSC_A_SCNTOVF);
  wire low = (priv < need);
  // A guest in supervisor mode touching hypervisor-level state is trapped to the host
  wire guest_h = virt && (need == 2'h2) && (priv == 2'h1);
  wire guest_u_s = virt && (priv == 2'h0) && (need == 2'h1);
  wire inh_ill = is_inh && !cde;
  wire inh_virt = is_inh && cde && virt;
  wire ovf_virt = is_ovf && cde && virt;
  wire v_any = inh_virt || ovf_virt || guest_h || guest_u_s;
  // Machine CSRs from below machine level give no hint they exist
  wire gen_ill = !known || (we && ro) || (low && !guest_h && !guest_u_s);
  assign virtual_exc = v_any && !inh_ill && !(!known || (we && ro));
  assign illegal = (inh_ill || gen_ill) && !virtual_exc;
endmodule

// ==== rtl/ssc_supervisor_csr.sv ====
/*
  Supervisor status trap stack, counter-inhibit alias and local
  counter-overflow interrupt bits of one hart.
  Assumes the pipeline issues one CSR request at a time, gives the
  trap and return strobes as one-cycle pulses, and that machine-level
  mode changes arrive on the privilege load strobe.
*/
`include "ssc_consts.svh"

module ssc_supervisor_csr
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // CSR request
  input wire logic CSR_REQ,
  input wire logic CSR_WE,
  input wire logic [11:0] CSR_ADDR,
  input wire logic [63:0] CSR_WDATA,
  // CSR answer
  output logic CSR_ACK,
  output logic [63:0] CSR_RDATA,
  output logic CSR_ILLEGAL,
  output logic CSR_VIRTUAL,
  // Trap and return strobes
  input wire logic TRAP_TAKE,
  input wire logic SUPERVISOR_RETURN_EXEC,
  input wire logic PRIV_LOAD,
  input wire logic [1:0] PRIV_LOAD_MODE,
  input wire logic PRIV_LOAD_VIRT,
  // Hart mode
  output logic [1:0] PRIV_MODE,
  output logic VIRT_MODE,
  // Interrupts
  input wire logic [15:0] IRQ_PEND,
  output logic IRQ_TAKE,
  // Counters
  input wire logic [31:0] CNT_OVF,
  output logic [31:0] CNT_INHIBIT,
  output logic [31:0] CNT_DELEG,
  // Local overflow interrupt state
  output logic LCOF_VPEND_M,
  output logic LCOF_VPEND_H
);

  // State
  logic sie_ff;
  logic sup_prior_irq_enable_ff;
  logic spp_ff;
  logic cde_ff;
  logic [31:0] cnten_ff;
  logic [31:0] cntinh_ff;
  logic [15:0] ien_ff;
  ssc_priv_t priv_ff;
  logic virt_ff;
  logic ack_ff;
  logic [63:0] rdata_ff;
  logic ill_ff;
  logic vexc_ff;
  logic irq_ff;
  logic [31:0] deleg_ff;
  logic [`SSC_NLCOF-1:0] lcof_q;

  // Address decode
  wire hit_sst = (CSR_ADDR == `SSC_A_SSTATUS);
  wire hit_mst = (CSR_ADDR == `SSC_A_MSTATUS);
  wire hit_sie = (CSR_ADDR == `SSC_A_SIE);
  wire hit_sinh = (CSR_ADDR == `SSC_A_SCNTINH);
  wire hit_minh = (CSR_ADDR == `SSC_A_MCNTINH);
  wire hit_cnten = (CSR_ADDR == `SSC_A_MCNTEN);
  wire hit_env = (CSR_ADDR == `SSC_A_MENVCFG);
  wire hit_ovf = (CSR_ADDR == `SSC_A_SCNTOVF);
  wire hit_mvip = (CSR_ADDR == `SSC_A_MVIP);
  wire hit_mvien = (CSR_ADDR == `SSC_A_MVIEN);
  wire hit_hvip = (CSR_ADDR == `SSC_A_HVIP);
  wire hit_hvien = (CSR_ADDR == `SSC_A_HVIEN);
  wire hit_vsie = (CSR_ADDR == `SSC_A_VSIE);
  wire hit_vsip = (CSR_ADDR == `SSC_A_VSIP);
  wire hit_mdel = (CSR_ADDR == `SSC_A_MIDELEG);
  wire hit_hdel = (CSR_ADDR == `SSC_A_HIDELEG);
  wire known = hit_sst | hit_mst | hit_sie | hit_sinh | hit_minh |
               hit_cnten | hit_env | hit_ovf | hit_mvip | hit_mvien |
               hit_hvip | hit_hvien | hit_vsie | hit_vsip | hit_mdel |
               hit_hdel;

  // Access check
  logic acc_ill;
  logic acc_virt;
  ssc_access_check u_check (
    .addr(CSR_ADDR),
    .we(CSR_WE),
    .known(known),
    .priv(priv_ff),
    .virt(virt_ff),
    .cde(cde_ff),
    .illegal(acc_ill),
    .virtual_exc(acc_virt)
  );

  wire wr = CSR_REQ && CSR_WE && !acc_ill && !acc_virt;
  // A trap or return in the same cycle owns the status bits
  wire st_wr = wr && (hit_sst || hit_mst) && !TRAP_TAKE && !SUPERVISOR_RETURN_EXEC;

  // Delegation mask
  wire [31:0] deleg = cnten_ff & {32{cde_ff}};
  // Alias view: delegated bits only, the rest read zero
  wire [31:0] sinh_view = cntinh_ff & deleg;
  wire [31:0] nxt_cntinh =
    (wr && hit_minh) ? CSR_WDATA[31:0] :
    (wr && hit_sinh) ? ((cntinh_ff & ~deleg) |
                        (CSR_WDATA[31:0] & deleg)) :
    cntinh_ff;

  // Trap stack next values
  wire from_user = (priv_ff == SSC_PRIV_U);
  wire nxt_spp = TRAP_TAKE ? !from_user :
                 SUPERVISOR_RETURN_EXEC ? 1'b0 :
                 st_wr ? CSR_WDATA[`SSC_B_SPP] : spp_ff;
  wire nxt_sup_prior_irq_enable = TRAP_TAKE ? sie_ff :
                  SUPERVISOR_RETURN_EXEC ? 1'b1 :
                  st_wr ? CSR_WDATA[`SSC_B_SUP_PRIOR_IRQ_ENABLE] : sup_prior_irq_enable_ff;
  wire nxt_sie = TRAP_TAKE ? 1'b0 :
                 SUPERVISOR_RETURN_EXEC ? sup_prior_irq_enable_ff :
                 st_wr ? CSR_WDATA[`SSC_B_SIE] : sie_ff;

  // Privilege next value
  wire [1:0] ret_priv = spp_ff ? SSC_PRIV_S : SSC_PRIV_U;
  wire [1:0] nxt_priv = TRAP_TAKE ? SSC_PRIV_S :
                        SUPERVISOR_RETURN_EXEC ? ret_priv :
                        PRIV_LOAD ? PRIV_LOAD_MODE : priv_ff;
  wire nxt_virt = TRAP_TAKE ? 1'b0 :
                  SUPERVISOR_RETURN_EXEC ? virt_ff :
                  PRIV_LOAD ? PRIV_LOAD_VIRT : virt_ff;

  // Interrupt gating
  wire any_en = |(IRQ_PEND & ien_ff);
  wire glob = (priv_ff == SSC_PRIV_U) ||
              ((priv_ff == SSC_PRIV_S) && sie_ff);
  wire nxt_irq = any_en && glob && !TRAP_TAKE;

  // Status word: same fields for both views, nothing machine-only shown
  wire [63:0] st_word = (64'h1 << `SSC_B_SIE) * {63'h0, sie_ff} |
                        (64'h1 << `SSC_B_SUP_PRIOR_IRQ_ENABLE) * {63'h0, sup_prior_irq_enable_ff} |
                        (64'h1 << `SSC_B_SPP) * {63'h0, spp_ff};

  // Local overflow bit cells
  wire [63:0] lcof_mask = 64'h1 << `SSC_B_LCOF;
  wire [`SSC_NLCOF-1:0] lcof_we;
  wire [`SSC_NLCOF-1:0] lcof_ok;
  assign lcof_we[`SSC_L_MVIP] = wr && hit_mvip;
  assign lcof_we[`SSC_L_MVIEN] = wr && hit_mvien;
  assign lcof_we[`SSC_L_HVIP] = wr && (hit_hvip || hit_vsip);
  assign lcof_we[`SSC_L_HVIEN] = wr && hit_hvien;
  assign lcof_we[`SSC_L_VSIE] = wr && hit_vsie;
  assign lcof_we[`SSC_L_MIDELEG] = wr && hit_mdel;
  assign lcof_we[`SSC_L_HIDELEG] = wr && hit_hdel;
  assign lcof_ok = {{2{`SSC_DELEG_LCOF_IMPL}}, 5'h1F};

  genvar gi;
  generate
    for (gi = 0; gi < `SSC_NLCOF; gi = gi + 1) begin : g_lcof
      ssc_bit_cell #(.RST_VAL(1'h0)) u_cell (
        .clk(SYS_CLK),
        .rst(RESET),
        .we(lcof_we[gi] && lcof_ok[gi]),
        .wd(CSR_WDATA[`SSC_B_LCOF]),
        .q(lcof_q[gi])
      );
    end
  endgenerate

  function automatic logic [63:0] lbit(input logic b);
    lbit = b ? (64'h1 << `SSC_B_LCOF) : 64'h0;
  endfunction

  // Read selection; guest pending bit mirrors the hypervisor cell
  wire [63:0] rd_val =
    ({64{hit_sst | hit_mst}} & st_word) |
    ({64{hit_sie}} & {48'h0, ien_ff}) |
    ({64{hit_sinh}} & {32'h0, sinh_view}) |
    ({64{hit_minh}} & {32'h0, cntinh_ff}) |
    ({64{hit_cnten}} & {32'h0, cnten_ff}) |
    ({64{hit_env}} & ({63'h0, cde_ff} << `SSC_B_CDE)) |
    ({64{hit_ovf}} & {32'h0, CNT_OVF & deleg_ff}) |
    ({64{hit_mvip}} & lbit(lcof_q[`SSC_L_MVIP])) |
    ({64{hit_mvien}} & lbit(lcof_q[`SSC_L_MVIEN])) |
    ({64{hit_hvip | hit_vsip}} & lbit(lcof_q[`SSC_L_HVIP])) |
    ({64{hit_hvien}} & lbit(lcof_q[`SSC_L_HVIEN])) |
    ({64{hit_vsie}} & lbit(lcof_q[`SSC_L_VSIE])) |
    ({64{hit_mdel}} & lbit(lcof_q[`SSC_L_MIDELEG])) |
    ({64{hit_hdel}} & lbit(lcof_q[`SSC_L_HIDELEG]));
  wire [63:0] nxt_rdata = (CSR_REQ && !acc_ill && !acc_virt) ?
                          (rd_val & (hit_mvip | hit_mvien | hit_hvip |
                           hit_vsip | hit_hvien | hit_vsie | hit_mdel |
                           hit_hdel ? lcof_mask : 64'hFFFFFFFFFFFFFFFF)) :
                          64'h0;

  // Trap stack and privilege
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      sie_ff <= `SSC_R_SIE;
      sup_prior_irq_enable_ff <= `SSC_R_SUP_PRIOR_IRQ_ENABLE;
      spp_ff <= `SSC_R_SPP;
      priv_ff <= SSC_PRIV_M;
      virt_ff <= 1'b0;
    end else begin
      sie_ff <= nxt_sie;
      sup_prior_irq_enable_ff <= nxt_sup_prior_irq_enable;
      spp_ff <= nxt_spp;
      priv_ff <= ssc_priv_t'(nxt_priv);
      virt_ff <= nxt_virt;
    end
  end

  // Configuration registers
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      cde_ff <= `SSC_R_CDE;
      cnten_ff <= `SSC_R_CNT;
      cntinh_ff <= `SSC_R_CNT;
      ien_ff <= `SSC_R_IEN;
      deleg_ff <= `SSC_R_CNT;
    end else begin
      if (wr && hit_env) begin
        cde_ff <= CSR_WDATA[`SSC_B_CDE];
      end
      if (wr && hit_cnten) begin
        cnten_ff <= CSR_WDATA[31:0];
      end
      if (wr && hit_sie) begin
        ien_ff <= CSR_WDATA[15:0];
      end
      cntinh_ff <= nxt_cntinh;
      deleg_ff <= deleg;
    end
  end

  // Answer and interrupt outputs
  always_ff @(posedge SYS_CLK or posedge RESET) begin
    if (RESET) begin
      ack_ff <= 1'b0;
      rdata_ff <= 64'h0;
      ill_ff <= 1'b0;
      vexc_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      ack_ff <= CSR_REQ;
      rdata_ff <= nxt_rdata;
      ill_ff <= CSR_REQ && acc_ill;
      vexc_ff <= CSR_REQ && acc_virt;
      irq_ff <= nxt_irq;
    end
  end

  // Counter-inhibit is registered, so counters see it one cycle late
  assign CSR_ACK = ack_ff;
  assign CSR_RDATA = rdata_ff;
  assign CSR_ILLEGAL = ill_ff;
  assign CSR_VIRTUAL = vexc_ff;
  assign PRIV_MODE = priv_ff;
  assign VIRT_MODE = virt_ff;
  assign IRQ_TAKE = irq_ff;
  assign CNT_INHIBIT = cntinh_ff;
  assign CNT_DELEG = deleg_ff;
  assign LCOF_VPEND_M = lcof_q[`SSC_L_MVIP];
  assign LCOF_VPEND_H = lcof_q[`SSC_L_HVIP];

endmodule

// ==== test/ssc_csr_properties.sv ====
/*
  Concurrent checks on the ports of the supervisor CSR block.
  Assumes the constants header is on the include path; bound below.
*/
`include "ssc_consts.svh"
module ssc_csr_properties
  import ssc_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic RESET,
  // CSR bus
  input wire logic CSR_REQ,
  input wire logic CSR_WE,
  input wire logic [11:0] CSR_ADDR,
  input wire logic [63:0] CSR_WDATA,
  input wire logic CSR_ACK,
  input wire logic [63:0] CSR_RDATA,
  input wire logic CSR_ILLEGAL,
  input wire logic CSR_VIRTUAL,
  // Strobes and mode
  input wire logic TRAP_TAKE,
  input wire logic SUPERVISOR_RETURN_EXEC,
  input wire logic PRIV_LOAD,
  input wire logic [1:0] PRIV_MODE,
  input wire logic VIRT_MODE,
  // Interrupts and counters
  input wire logic [15:0] IRQ_PEND,
  input wire logic IRQ_TAKE,
  input wire logic [31:0] CNT_INHIBIT,
  input wire logic [31:0] CNT_DELEG,
  input wire logic LCOF_VPEND_M,
  input wire logic LCOF_VPEND_H
);
  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (RESET);

  // A return with no trap beside it, since the trap wins
  sequence s_ret;
    SUPERVISOR_RETURN_EXEC && !TRAP_TAKE;
  endsequence
  sequence s_quiet;
    !SUPERVISOR_RETURN_EXEC && !TRAP_TAKE && !PRIV_LOAD;
  endsequence
  sequence s_inh_write;
    CSR_REQ && CSR_WE && CSR_ADDR == `SSC_A_SCNTINH;
  endsequence

  a_ack_one_cycle: assert property (CSR_REQ |=> CSR_ACK)
    else $error("answer not one cycle after request");
  a_idle_quiet: assert property (!CSR_REQ |=> !CSR_ACK && CSR_RDATA == 64'h0)
    else $error("answer without request");
  a_trap_enters_sup: assert property (TRAP_TAKE |=>
    PRIV_MODE == SSC_PRIV_S && !VIRT_MODE && !IRQ_TAKE)
    else $error("trap entry state wrong");
  a_ret_twice_user: assert property (s_ret ##1 s_ret |=>
    PRIV_MODE == SSC_PRIV_U)
    else $error("second return not to user");
  a_trap_user_back: assert property (TRAP_TAKE && PRIV_MODE == SSC_PRIV_U
    ##1 s_quiet ##1 s_ret |=> PRIV_MODE == SSC_PRIV_U)
    else $error("return after user trap not to user");
  a_masked_quiet: assert property (IRQ_PEND == 16'h0 |=> !IRQ_TAKE)
    else $error("interrupt with nothing pending");
  a_inh_masked: assert property (s_inh_write |=>
    ((CNT_INHIBIT ^ $past(CNT_INHIBIT)) & ~$past(CNT_DELEG)) == 32'h0)
    else $error("undelegated inhibit bit changed");
  a_inh_alias: assert property (s_inh_write |=> CSR_ILLEGAL || CSR_VIRTUAL ||
    (CNT_INHIBIT & $past(CNT_DELEG)) ==
    (32'($past(CSR_WDATA)) & $past(CNT_DELEG)))
    else $error("delegated inhibit bit not written");
  a_guest_inh_refused: assert property (CSR_REQ && VIRT_MODE &&
    CSR_ADDR == `SSC_A_SCNTINH |=> CSR_ILLEGAL ^ CSR_VIRTUAL)
    else $error("guest inhibit access not refused");
  a_mach_csr_refused: assert property (CSR_REQ && CSR_ADDR[9:8] == 2'h3 &&
    PRIV_MODE != SSC_PRIV_M |=> CSR_ILLEGAL && CSR_RDATA == 64'h0)
    else $error("machine CSR visible below machine");
  a_lcof_mvip: assert property (CSR_REQ && CSR_WE && CSR_ADDR == `SSC_A_MVIP
    && PRIV_MODE == SSC_PRIV_M |=> LCOF_VPEND_M == $past(CSR_WDATA[13]))
    else $error("machine virtual pending bit not written");
  a_lcof_hvip: assert property (CSR_REQ && CSR_WE && CSR_ADDR == `SSC_A_HVIP
    && PRIV_MODE == SSC_PRIV_M |=> LCOF_VPEND_H == $past(CSR_WDATA[13]))
    else $error("hypervisor virtual pending bit not written");
endmodule

bind ssc_supervisor_csr ssc_csr_properties u_props (.*);

// ==== test/test_supervisor_status_trap_csr.sv ====
/*
  Self-checking bench for the supervisor CSR block.
  Assumes the checker file is compiled ahead and binds itself.
*/
`include "ssc_consts.svh"
module test_supervisor_status_trap_csr import ssc_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic SYS_CLK = 1'h0;
  logic RESET = 1'h1;
  logic CSR_REQ = 1'h0;
  logic CSR_WE = 1'h0;
  logic [11:0] CSR_ADDR = 12'h0;
  logic [63:0] CSR_WDATA = 64'h0;
  logic TRAP_TAKE = 1'h0;
  logic SUPERVISOR_RETURN_EXEC = 1'h0;
  logic PRIV_LOAD = 1'h0;
  logic [1:0] PRIV_LOAD_MODE = 2'h0;
  logic PRIV_LOAD_VIRT = 1'h0;
  logic [15:0] IRQ_PEND = 16'h0;
  logic [31:0] CNT_OVF = 32'hFF;
  logic CSR_ACK, CSR_ILLEGAL, CSR_VIRTUAL, VIRT_MODE, IRQ_TAKE;
  logic LCOF_VPEND_M, LCOF_VPEND_H;
  logic [63:0] CSR_RDATA;
  logic [1:0] PRIV_MODE;
  logic [31:0] CNT_INHIBIT, CNT_DELEG;
  logic [63:0] rd;
  int err_count = 0;
  int compares = 0;

  always #10 SYS_CLK = ~SYS_CLK;

  ssc_supervisor_csr dut (.*);

  task automatic finish_test();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask

  // One access; the answer is fixed at one cycle, so no open wait
  task automatic csr(input logic w, input logic [11:0] a, input logic [63:0] d,
                     input logic [1:0] ef);
    @(posedge SYS_CLK);
    CSR_REQ <= 1'h1;
    CSR_WE <= w;
    CSR_ADDR <= a;
    CSR_WDATA <= d;
    @(posedge SYS_CLK);
    CSR_REQ <= 1'h0;
    #1;
    chk("ack", 64'h1, 64'(CSR_ACK));
    chk("verdict", 64'(ef), 64'({CSR_ILLEGAL, CSR_VIRTUAL}));
    rd = CSR_RDATA;
  endtask

  task automatic ev(input logic t, input logic s, input logic l,
                    input logic [1:0] m, input logic v);
    @(posedge SYS_CLK);
    TRAP_TAKE <= t;
    SUPERVISOR_RETURN_EXEC <= s;
    PRIV_LOAD <= l;
    PRIV_LOAD_MODE <= m;
    PRIV_LOAD_VIRT <= v;
    @(posedge SYS_CLK);
    TRAP_TAKE <= 1'h0;
    SUPERVISOR_RETURN_EXEC <= 1'h0;
    PRIV_LOAD <= 1'h0;
    #1;
  endtask

  task automatic go(input logic [1:0] m, input logic v);
    ev(1'h0, 1'h0, 1'h1, m, v);
  endtask

  // Interrupt output is registered, so give it two edges
  task automatic settle();
    repeat (2) @(posedge SYS_CLK);
    #1;
  endtask

  task automatic t_status();
    csr(1'h1, `SSC_A_SSTATUS, 64'h22, 2'h0);
    csr(1'h0, `SSC_A_MSTATUS, 64'h0, 2'h0);
    chk("mstatus view", 64'h22, rd);
    go(SSC_PRIV_S, 1'h0);
    csr(1'h1, `SSC_A_SSTATUS, '1, 2'h0);
    csr(1'h0, `SSC_A_SSTATUS, 64'h0, 2'h0);
    chk("sstatus layout", 64'h122, rd);
    csr(1'h0, `SSC_A_MSTATUS, 64'h0, 2'h2);
    csr(1'h0, 12'h5C0, 64'h0, 2'h2);
    go(SSC_PRIV_M, 1'h0);
  endtask

  task automatic t_trap();
    csr(1'h1, `SSC_A_SSTATUS, 64'h2, 2'h0);
    go(SSC_PRIV_U, 1'h0);
    ev(1'h1, 1'h0, 1'h0, 2'h0, 1'h0);
    chk("trap mode", 64'(SSC_PRIV_S), 64'(PRIV_MODE));
    ev(1'h0, 1'h1, 1'h0, 2'h0, 1'h0);
    chk("ret user", 64'(SSC_PRIV_U), 64'(PRIV_MODE));
    go(SSC_PRIV_S, 1'h0);
    csr(1'h0, `SSC_A_SSTATUS, 64'h0, 2'h0);
    chk("ret stack", 64'h22, rd);
    ev(1'h1, 1'h0, 1'h0, 2'h0, 1'h0);
    csr(1'h0, `SSC_A_SSTATUS, 64'h0, 2'h0);
    chk("trap stack", 64'h120, rd);
    @(posedge SYS_CLK);
    SUPERVISOR_RETURN_EXEC <= 1'h1;
    @(posedge SYS_CLK);
    #1;
    chk("ret sup", 64'(SSC_PRIV_S), 64'(PRIV_MODE));
    @(posedge SYS_CLK);
    SUPERVISOR_RETURN_EXEC <= 1'h0;
    #1;
    chk("ret cleared", 64'(SSC_PRIV_U), 64'(PRIV_MODE));
    go(SSC_PRIV_M, 1'h0);
    csr(1'h0, `SSC_A_SSTATUS, 64'h0, 2'h0);
    chk("double ret", 64'h22, rd);
  endtask

  task automatic t_irq();
    csr(1'h1, `SSC_A_SIE, 64'h20, 2'h0);
    csr(1'h1, `SSC_A_SSTATUS, 64'h0, 2'h0);
    go(SSC_PRIV_S, 1'h0);
    IRQ_PEND <= 16'h20;
    settle();
    chk("sup masked", 64'h0, 64'(IRQ_TAKE));
    go(SSC_PRIV_U, 1'h0);
    settle();
    chk("user enabled", 64'h1, 64'(IRQ_TAKE));
    IRQ_PEND <= 16'h2;
    settle();
    chk("source masked", 64'h0, 64'(IRQ_TAKE));
    go(SSC_PRIV_M, 1'h0);
    csr(1'h1, `SSC_A_SSTATUS, 64'h2, 2'h0);
    go(SSC_PRIV_S, 1'h0);
    IRQ_PEND <= 16'h20;
    settle();
    chk("sup enabled", 64'h1, 64'(IRQ_TAKE));
    ev(1'h1, 1'h0, 1'h0, 2'h0, 1'h0);
    settle();
    chk("trap masks", 64'h0, 64'(IRQ_TAKE));
    IRQ_PEND <= 16'h0;
    go(SSC_PRIV_M, 1'h0);
  endtask

  task automatic t_cnt();
    csr(1'h1, `SSC_A_MCNTEN, 64'h5, 2'h0);
    go(SSC_PRIV_S, 1'h0);
    csr(1'h0, `SSC_A_SCNTINH, 64'h0, 2'h2);
    go(SSC_PRIV_M, 1'h0);
    csr(1'h1, `SSC_A_MENVCFG, 64'h1 << `SSC_B_CDE, 2'h0);
    settle();
    chk("deleg mask", 64'h5, 64'(CNT_DELEG));
    go(SSC_PRIV_S, 1'h0);
    csr(1'h1, `SSC_A_SCNTINH, 64'hF, 2'h0);
    chk("alias write", 64'h5, 64'(CNT_INHIBIT));
    go(SSC_PRIV_M, 1'h0);
    csr(1'h1, `SSC_A_MCNTINH, 64'hA, 2'h0);
    go(SSC_PRIV_S, 1'h0);
    csr(1'h0, `SSC_A_SCNTINH, 64'h0, 2'h0);
    chk("alias read", 64'h0, rd);
    csr(1'h0, `SSC_A_SCNTOVF, 64'h0, 2'h0);
    chk("overflow view", 64'h5, rd);
    go(SSC_PRIV_S, 1'h1);
    csr(1'h0, `SSC_A_SCNTINH, 64'h0, 2'h1);
    csr(1'h0, `SSC_A_SCNTOVF, 64'h0, 2'h1);
    go(SSC_PRIV_M, 1'h0);
  endtask

  task automatic t_lcof();
    logic [11:0] al [8] = '{`SSC_A_MVIP, `SSC_A_MVIEN, `SSC_A_HVIP,
      `SSC_A_HVIEN, `SSC_A_VSIE, `SSC_A_VSIP, `SSC_A_MIDELEG, `SSC_A_HIDELEG};
    foreach (al[i]) begin
      csr(1'h1, al[i], '1, 2'h0);
      csr(1'h0, al[i], 64'h0, 2'h0);
      chk("overflow bit", 64'h2000, rd);
    end
    chk("mvip out", 64'h1, 64'(LCOF_VPEND_M));
    chk("hvip out", 64'h1, 64'(LCOF_VPEND_H));
    csr(1'h1, `SSC_A_VSIP, 64'h0, 2'h0);
    chk("vsip alias", 64'h0, 64'(LCOF_VPEND_H));
  endtask

  // Guards against a hang anywhere in the sequence
  initial begin
    repeat (20000) @(posedge SYS_CLK);
    err_count++;
    finish_test();
  end

  initial begin
    repeat (12) @(posedge SYS_CLK);
    RESET <= 1'h0;
    @(posedge SYS_CLK);
    #1;
    chk("reset mode", 64'(SSC_PRIV_M), 64'(PRIV_MODE));
    t_status();
    t_trap();
    t_irq();
    t_cnt();
    t_lcof();
    finish_test();
  end
endmodule
